//--- rss_chk_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rss_chk (
  input wire logic                    clk_sys_i,            // Clock.
  input wire logic                    rstn_i,               // Reset, active low.
  input wire logic                    event_mark_input_one, // Mark pin 1.
  input wire rss_pkg::rss_health_type health_i,             // Health.
  input wire logic [3:0]              mark_event_o,         // Mark events.
  input wire logic                    freq_output_one,      // Freq out 1.
  input wire logic                    receiver_ready_out,   // Ready.
  input wire logic                    error_o,              // Error.
  input wire logic                    pos_valid_o,          // Position valid.
  input wire logic                    reset_busy_o          // Reset busy.
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_err_pv; error_o |-> !pos_valid_o; endproperty
  a_err_pv: assert property (p_err_pv) else $error("position valid with error");
  property p_busy; reset_busy_o |-> !receiver_ready_out; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_run; $fell(reset_busy_o) |=> receiver_ready_out; endproperty
  a_run: assert property (p_run) else $error("ready late");
  property p_nf; receiver_ready_out && health_i.nonfatal && !health_i.fatal
    |=> error_o && receiver_ready_out; endproperty
  a_nf: assert property (p_nf) else $error("nonfatal handling wrong");
  property p_err_lo; !health_i.nonfatal |=> !error_o; endproperty
  a_err_lo: assert property (p_err_lo) else $error("error without cause");
  property p_fatal; receiver_ready_out && health_i.fatal
    |=> (!receiver_ready_out && !error_o && !pos_valid_o) [*8]; endproperty
  a_fatal: assert property (p_fatal) else $error("fatal did not clear status");
  property p_pv; pos_valid_o |-> $past(health_i.pos_ok) && !$past(health_i.nonfatal);
  endproperty
  a_pv: assert property (p_pv) else $error("position valid without solution");
  property p_mark; mark_event_o[0]
    |-> $past(event_mark_input_one, 3) == $past(event_mark_input_one, 4)
     && $past(event_mark_input_one, 4) == $past(event_mark_input_one, 5); endproperty
  a_mark: assert property (p_mark) else $error("mark event without pulse");
  property p_once; |mark_event_o |=> (mark_event_o & $past(mark_event_o)) == 4'h0;
  endproperty
  a_once: assert property (p_once) else $error("mark event too long");
  property p_idle; reset_busy_o && $past(reset_busy_o) |-> freq_output_one; endproperty
  a_idle: assert property (p_idle) else $error("freq output active in reset");
  c_fatal: cover property (receiver_ready_out && health_i.fatal);
  c_err: cover property (error_o && receiver_ready_out);
  c_mark: cover property (|mark_event_o);
endmodule // rss_chk
bind rss_top rss_chk u_chk (.clk_sys_i, .rstn_i, .event_mark_input_one, .health_i,
  .mark_event_o, .freq_output_one, .receiver_ready_out, .error_o, .pos_valid_o,
  .reset_busy_o);
`default_nettype wire

//--- rss_far_end.sv
`timescale 1ns/100ps
`default_nettype none
// Host and timing gear: drives the mark pins and the reset pin at the falling edge.
module rss_far_end (
  input  wire logic       clk_sys_i, // Clock.
  output var  logic [3:0] mark_o,    // Mark pins.
  output var  logic       xrst_n_o   // Reset pin, active low.
);
  logic [3:0] pl = 4'h0;
  // The reset pin is held low from power-up until power_up lets it go.
  initial begin
    mark_o = 4'hF;
    xrst_n_o = 1'b0;
  end
  // Parks every mark pin inactive in the same step as the polarity change, so no edge is faked.
  task automatic idle(input logic [3:0] p);
    pl = p;
    mark_o = ~p;
  endtask
  task automatic pulse(input int i, input int w);
    @(negedge clk_sys_i);
    mark_o[i] = pl[i];
    repeat (w) @(negedge clk_sys_i);
    mark_o[i] = ~pl[i];
  endtask
  task automatic xrst(input int n);
    @(negedge clk_sys_i);
    xrst_n_o = 1'b0;
    repeat (n) @(negedge clk_sys_i);
    xrst_n_o = 1'b1;
  endtask
  // Power-up hold, scaled far below the recommended settling time to keep runs short.
  task automatic power_up(input int n);
    repeat (n) @(negedge clk_sys_i);
    xrst_n_o = 1'b1;
  endtask
endmodule // rss_far_end
`default_nettype wire

//--- rss_freq_gen.sv
`timescale 1ns/100ps
`default_nettype none
// One programmable square-wave output, active low; the count runs in half periods.
module rss_freq_gen (
  input  wire logic                     clk_sys_i,   // System clock.
  input  wire logic                     rstn_i,      // Async reset, active low.
  input  wire logic                     run_i,       // Device running.
  input  wire logic [rss_pkg::DIV_W-1:0] half_i,     // Half period in cycles, 0 stops.
  output logic                          freq_n_o     // Output, active low.
);

  logic [rss_pkg::DIV_W-1:0] cnt_q;
  logic [rss_pkg::DIV_W-1:0] cnt_d;
  logic                      lvl_q;
  logic                      lvl_d;

  always_comb begin
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    if (!run_i || half_i == '0) begin
      cnt_d = '0;
      lvl_d = 1'b0;
    end else if (cnt_q + 32'h0000_0001 >= half_i) begin
      cnt_d = '0;
      lvl_d = ~lvl_q;
    end else begin
      cnt_d = cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  // Idle output is inactive, that is high.
  assign freq_n_o = ~lvl_q;

endmodule // rss_freq_gen
`default_nettype wire

//--- rss_pkg.sv
package rss_pkg;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MARK_MIN_NS      = 150;
  // Pulse must be longer than the minimum, so one cycle more than the rounded-up count.
  localparam int unsigned MARK_MIN_CYC     = (MARK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned EXT_RST_MIN_US   = 20;
  localparam int unsigned EXT_RST_MIN_CYC  = (EXT_RST_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  localparam int unsigned BOOT_CYC         = 16;
  localparam int unsigned NUM_MARKS        = 4;
  localparam int unsigned NUM_FREQ         = 4;
  localparam int unsigned CNT_W            = 16;
  localparam int unsigned DIV_W            = 32;
  localparam logic [3:0]  MARK_POL_RESET   = 4'h0;
  localparam logic [DIV_W-1:0] DIV_RESET   = 32'h0000_0000;

  typedef enum logic [1:0] {
    RSS_ST_RESET,
    RSS_ST_BOOT,
    RSS_ST_RUN
  } rss_state_type;

  typedef struct packed {
    logic fatal;
    logic nonfatal;
    logic pos_ok;
  } rss_health_type;

  typedef struct packed {
    logic error;
    logic ready;
    logic pos_valid;
  } rss_status_type;

endpackage

//--- rss_top.sv
`timescale 1ns/100ps
`default_nettype none
module rss_top (
  input  wire logic                          clk_sys_i,              // System clock, 10 MHz.
  input  wire logic                          rstn_i,                 // Async reset, active low.
  input  wire logic                          external_reset_n_input, // Reset pin, active low.
  input  wire logic                          event_mark_input_one,   // Mark input 1.
  input  wire logic                          event_mark_input_two,   // Mark input 2.
  input  wire logic                          event_mark_input_three, // Mark input 3.
  input  wire logic                          event_mark_input_four,  // Mark input 4.
  input  wire logic [3:0]                    mark_pol_i,             // 1 = mark active high.
  input  wire logic [rss_pkg::DIV_W-1:0]     freq_half_one_i,        // Half period out 1.
  input  wire logic [rss_pkg::DIV_W-1:0]     freq_half_two_i,        // Half period out 2.
  input  wire logic [rss_pkg::DIV_W-1:0]     freq_half_three_i,      // Half period out 3.
  input  wire logic [rss_pkg::DIV_W-1:0]     freq_half_four_i,       // Half period out 4.
  input  wire logic                          cfg_load_i,             // Load configuration.
  input  wire logic                          boot_done_i,            // Firmware boot done.
  input  wire rss_pkg::rss_health_type       health_i,               // Receiver health.
  output logic [3:0]                         mark_event_o,           // Accepted mark pulse.
  output logic                               freq_output_one,        // Freq out 1, low active.
  output logic                               freq_output_two,        // Freq out 2, low active.
  output logic                               freq_output_three,      // Freq out 3, low active.
  output logic                               freq_output_four,       // Freq out 4, low active.
  output logic                               receiver_ready_out,     // Ready for commands.
  output logic                               error_o,                // Error flag.
  output logic                               pos_valid_o,            // Position valid.
  output logic                               reset_busy_o            // Internal reset active.
);

  // Width of the reset-pin counter; it leaves room to raise the minimum width.
  localparam int unsigned RW = 24;

  // Running is decoded for the busy flag and for the output generators, so it lives here.
  function automatic logic is_running(input rss_pkg::rss_state_type st);
    return st == rss_pkg::RSS_ST_RUN;
  endfunction

  // Pin synchronisers. They reset to the idle level of an active-low pin, so releasing
  // reset cannot look like a leading edge on a mark input or a low on the reset pin.
  // Health, boot and configuration come from logic on this clock and need none.
  logic [3:0] mk_s1_q;
  logic [3:0] mk_s2_q;
  logic       rp_s1_q;
  logic       rp_s2_q;
  logic [3:0] mk_raw;

  // Bit i of every mark vector belongs to mark input i+1.
  assign mk_raw = {event_mark_input_four, event_mark_input_three,
                   event_mark_input_two, event_mark_input_one};

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mk_s1_q <= 4'hF;
      mk_s2_q <= 4'hF;
      rp_s1_q <= 1'b1;
      rp_s2_q <= 1'b1;
    end else begin
      mk_s1_q <= mk_raw;
      mk_s2_q <= mk_s1_q;
      rp_s1_q <= external_reset_n_input;
      rp_s2_q <= rp_s1_q;
    end
  end

  // External reset pulse width measurement. The counter stops at the minimum width, so
  // the internal reset stands for as long as the pin stays low and ends at once after it.
  // Shorter pulses are taken as noise and leave a running receiver alone.
  logic [RW-1:0] rcnt_q;
  logic [RW-1:0] rcnt_d;
  logic          xrst_q;
  logic          xrst_d;

  always_comb begin
    rcnt_d = rcnt_q;
    xrst_d = xrst_q;
    if (!rp_s2_q) begin
      if (rcnt_q < RW'(rss_pkg::EXT_RST_MIN_CYC)) begin
        rcnt_d = rcnt_q + 24'h00_0001;
      end else begin
        xrst_d = 1'b1;
      end
    end else begin
      rcnt_d = '0;
      xrst_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rcnt_q <= '0;
      xrst_q <= 1'b0;
    end else begin
      rcnt_q <= rcnt_d;
      xrst_q <= xrst_d;
    end
  end

  // Configuration registers, loaded by a configuration command strobe.
  // A pin reset restores the defaults, so a load that falls into it is lost and the
  // host has to repeat it once ready is back.
  logic [3:0]               pol_q;
  logic [3:0]               pol_d;
  logic [rss_pkg::DIV_W-1:0] half_q [rss_pkg::NUM_FREQ];
  logic [rss_pkg::DIV_W-1:0] half_d [rss_pkg::NUM_FREQ];

  always_comb begin
    pol_d = pol_q;
    for (int i = 0; i < rss_pkg::NUM_FREQ; i++) begin
      half_d[i] = half_q[i];
    end
    if (xrst_q) begin
      pol_d = rss_pkg::MARK_POL_RESET;
      for (int i = 0; i < rss_pkg::NUM_FREQ; i++) begin
        half_d[i] = rss_pkg::DIV_RESET;
      end
    end else if (cfg_load_i) begin
      pol_d     = mark_pol_i;
      half_d[0] = freq_half_one_i;
      half_d[1] = freq_half_two_i;
      half_d[2] = freq_half_three_i;
      half_d[3] = freq_half_four_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pol_q <= rss_pkg::MARK_POL_RESET;
      for (int i = 0; i < rss_pkg::NUM_FREQ; i++) begin
        half_q[i] <= rss_pkg::DIV_RESET;
      end
    end else begin
      pol_q <= pol_d;
      for (int i = 0; i < rss_pkg::NUM_FREQ; i++) begin
        half_q[i] <= half_d[i];
      end
    end
  end

  // Mark qualification: the event fires once the active level has lasted the minimum width.
  // The trade-off is a fixed latency of the minimum width after the leading edge.
  // A mark has to go inactive for one cycle, or see a pin reset, before it can fire again.
  logic [3:0]                 act;
  logic [3:0]                 fired_q;
  logic [3:0]                 fired_d;
  logic [3:0]                 ev_q;
  logic [3:0]                 ev_d;
  logic [rss_pkg::CNT_W-1:0]  wcnt_q [rss_pkg::NUM_MARKS];
  logic [rss_pkg::CNT_W-1:0]  wcnt_d [rss_pkg::NUM_MARKS];

  assign act = mk_s2_q ^ ~pol_q;

  always_comb begin
    fired_d = fired_q;
    ev_d    = 4'h0;
    for (int i = 0; i < rss_pkg::NUM_MARKS; i++) begin
      wcnt_d[i] = wcnt_q[i];
      if (!act[i] || xrst_q) begin
        wcnt_d[i]  = '0;
        fired_d[i] = 1'b0;
      end else if (!fired_q[i]) begin
        if (wcnt_q[i] + 16'h0001 >= rss_pkg::CNT_W'(rss_pkg::MARK_MIN_CYC)) begin
          fired_d[i] = 1'b1;
          ev_d[i]    = 1'b1;
        end else begin
          wcnt_d[i] = wcnt_q[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fired_q <= 4'h0;
      ev_q    <= 4'h0;
      for (int i = 0; i < rss_pkg::NUM_MARKS; i++) begin
        wcnt_q[i] <= '0;
      end
    end else begin
      fired_q <= fired_d;
      ev_q    <= ev_d;
      for (int i = 0; i < rss_pkg::NUM_MARKS; i++) begin
        wcnt_q[i] <= wcnt_d[i];
      end
    end
  end

  // One pulse per accepted mark, registered so that the host sees a clean strobe.
  assign mark_event_o = ev_q;

  // Device state and status outputs. The fatal branch and the pin-reset check each clear the whole status vector, so a fatal
  // error and a pin reset drop ready, error and position valid in the same cycle.
  // The boot wait is only a floor: the firmware decides when booting is over.
  rss_pkg::rss_state_type   st_q;
  rss_pkg::rss_state_type   st_d;
  logic [7:0]               bcnt_q;
  logic [7:0]               bcnt_d;
  rss_pkg::rss_status_type  stat_q;
  rss_pkg::rss_status_type  stat_d;
  logic                     busy_q;
  logic                     busy_d;

  always_comb begin
    st_d   = st_q;
    bcnt_d = bcnt_q;
    stat_d = '0;
    unique case (st_q)
      rss_pkg::RSS_ST_RESET: begin
        // One cycle here clears the boot count before booting starts again.
        bcnt_d = '0;
        if (!xrst_q) begin
          st_d = rss_pkg::RSS_ST_BOOT;
        end
      end
      rss_pkg::RSS_ST_BOOT: begin
        if (bcnt_q < 8'(rss_pkg::BOOT_CYC)) begin
          bcnt_d = bcnt_q + 8'h01;
        end
        if (bcnt_q >= 8'(rss_pkg::BOOT_CYC) && boot_done_i) begin
          st_d = rss_pkg::RSS_ST_RUN;
        end
      end
      rss_pkg::RSS_ST_RUN: begin
        stat_d.ready     = 1'b1;
        stat_d.error     = health_i.nonfatal;
        // Position valid is gated by the error flag, so it falls in the cycle the error rises.
        stat_d.pos_valid = health_i.pos_ok && !health_i.nonfatal;
        if (health_i.fatal) begin
          st_d   = rss_pkg::RSS_ST_RESET;
          stat_d = '0;
        end
      end
      // The fourth code is never entered; should it appear, the receiver reboots.
      default: begin
        st_d = rss_pkg::RSS_ST_RESET;
      end
    endcase
    if (xrst_q) begin
      st_d   = rss_pkg::RSS_ST_RESET;
      stat_d = '0;
    end
    busy_d = !is_running(st_d);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q   <= rss_pkg::RSS_ST_RESET;
      bcnt_q <= '0;
      stat_q <= '0;
      busy_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      bcnt_q <= bcnt_d;
      stat_q <= stat_d;
      busy_q <= busy_d;
    end
  end

  assign receiver_ready_out = stat_q.ready;
  assign error_o            = stat_q.error;
  assign pos_valid_o        = stat_q.pos_valid;
  // Busy is registered from the next state, so it falls on the edge that enters run.
  assign reset_busy_o       = busy_q;

  logic       run;
  logic [3:0] fo;

  // The generators go to their idle level one cycle after the running state is left, so the outputs
  // stay inactive through boot and reset after that first cycle. Each level lasts at least one cycle, which
  // limits the fastest output to half the system clock.
  assign run = is_running(st_q);

  for (genvar g = 0; g < rss_pkg::NUM_FREQ; g++) begin : g_freq
    rss_freq_gen u_gen (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .run_i     (run),
      .half_i    (half_q[g]),
      .freq_n_o  (fo[g])
    );
  end

  assign freq_output_one   = fo[0];
  assign freq_output_two   = fo[1];
  assign freq_output_three = fo[2];
  assign freq_output_four  = fo[3];

endmodule // rss_top
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                    clk_sys_i, rstn_i, cfg_load_i, boot_done_i, busy, xn;
  logic [3:0]              mark_pol_i, mk, ev, fo;
  logic [31:0]             hf [4];
  logic [31:0]             lf = 32'h6A2A;
  logic [3:0]              q [$];
  rss_pkg::rss_health_type health_i;
  rss_pkg::rss_status_type st;
  int                      n_errors = 0, n_compared = 0;
  rss_far_end far (.clk_sys_i, .mark_o(mk), .xrst_n_o(xn));
  rss_top dut (.clk_sys_i, .rstn_i, .external_reset_n_input(xn),
    .event_mark_input_one(mk[0]), .event_mark_input_two(mk[1]),
    .event_mark_input_three(mk[2]), .event_mark_input_four(mk[3]), .mark_pol_i,
    .freq_half_one_i(hf[0]), .freq_half_two_i(hf[1]), .freq_half_three_i(hf[2]),
    .freq_half_four_i(hf[3]), .cfg_load_i, .boot_done_i, .health_i, .mark_event_o(ev),
    .freq_output_one(fo[0]), .freq_output_two(fo[1]), .freq_output_three(fo[2]),
    .freq_output_four(fo[3]), .receiver_ready_out(st.ready), .error_o(st.error),
    .pos_valid_o(st.pos_valid), .reset_busy_o(busy));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    $display("Counts: compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic note(input logic ok, input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (!ok) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic cmp_st(input rss_pkg::rss_status_type e);
    note(st === e, 32'(st), 32'(e));
  endtask
  task automatic cmp_ev(input logic [3:0] a, input logic [3:0] e);
    note(a === e, 32'(a), 32'(e));
  endtask
  task automatic cmp_per(input logic [31:0] a, input logic [31:0] e);
    note(a === e, a, e);
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    while (st.ready !== 1'b1 && k < 400) begin
      @(negedge clk_sys_i);
      k++;
    end
    if (k == 400) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic wl(input int i, input logic v, output int k);
    k = 0;
    while (fo[i] !== v && k < 99) begin
      @(negedge clk_sys_i);
      k++;
    end
    if (k == 99) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic load(input logic [3:0] p);
    mark_pol_i = p;
    far.idle(p);
    cfg_load_i = 1'b1;
    @(negedge clk_sys_i);
    cfg_load_i = 1'b0;
  endtask
  // A long pulse gives one event; the one-cycle glitch right after it gives none.
  task automatic marks(input logic [3:0] p);
    load(p);
    repeat (5) @(negedge clk_sys_i);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      q.push_back(4'h1 << i);
      far.pulse(i, 3 + int'(lf[2:0]));
      far.pulse(i, 1);
      repeat (8) @(negedge clk_sys_i);
    end
    cmp_ev(4'(q.size()), 4'h0);
    $display("Test marks done");
  endtask
  always @(negedge clk_sys_i) begin
    if (ev !== 4'h0) begin
      if (q.size() == 0) cmp_ev(ev, 4'h0);
      else cmp_ev(ev, q.pop_front());
    end
  end
  initial begin
    int a;
    int b;
    int g;
    {rstn_i, cfg_load_i, boot_done_i, mark_pol_i} = 7'h00;
    health_i = 3'h1;
    for (int i = 0; i < 4; i++) hf[i] = 32'h0;
    far.power_up(6);
    rstn_i = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    cmp_st(3'h0);
    boot_done_i = 1'b1;
    wait_rdy();
    cmp_st(3'h3);
    $display("Test boot done");
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      hf[i] = {30'h0, lf[1:0]} + 32'h1;
    end
    load(4'h0);
    for (int i = 0; i < 4; i++) begin
      wl(i, 1'b1, a);
      wl(i, 1'b0, a);
      wl(i, 1'b1, a);
      wl(i, 1'b0, b);
      cmp_per(32'(a + b), hf[i] << 1);
    end
    $display("Test freq done");
    marks(4'hF);
    marks(4'h0);
    for (int j = 0; j < 4; j++) begin
      g = j ^ (j >> 1);
      health_i = 3'(g);
      @(negedge clk_sys_i);
      cmp_st({g[1], 1'b1, g[0] & ~g[1]});
    end
    health_i = 3'h5;
    @(negedge clk_sys_i);
    cmp_st(3'h0);
    health_i = 3'h1;
    repeat (10) @(negedge clk_sys_i);
    cmp_st(3'h0);
    wait_rdy();
    cmp_st(3'h3);
    $display("Test status done");
    far.xrst(50);
    repeat (5) @(negedge clk_sys_i);
    cmp_st(3'h3);
    far.xrst(210);
    repeat (2) @(negedge clk_sys_i);
    cmp_st(3'h0);
    wait_rdy();
    repeat (4) @(negedge clk_sys_i);
    cmp_ev(fo, 4'hF);
    $display("Test reset done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
